/* File: ldcr_pkg.sv */
// Purpose: Constants and types for the laser driver control register bank.
// Assumes: Register numbers serve as offsets.
// Notes: Core registers 0 to 3 and transmit register 10.
package ldcr_pkg;

    // Seven-bit serial slave address
    localparam logic [6:0] DEV_ADDR = 7'h08;

    // Register offsets
    localparam logic [7:0] OFS_CORE_RESET_ENABLE = 8'h00;
    localparam logic [7:0] OFS_BIAS_LOOP_CONFIG = 8'h01;
    localparam logic [7:0] OFS_CORE_RESERVED_TWO = 8'h02;
    localparam logic [7:0] OFS_CONVERTER_CONTROL = 8'h03;
    localparam logic [7:0] OFS_TRANSMIT_PATH_CONTROL = 8'h0A;

    // Reset values
    localparam logic [7:0] RST_CORE_RESET_ENABLE = 8'h41;
    localparam logic [7:0] RST_BIAS_LOOP_CONFIG = 8'h00;
    localparam logic [7:0] RST_CORE_RESERVED_TWO = 8'h00;
    localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_PATH_CONTROL = 8'h00;

    // Value read from an unmapped offset
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Core register 0: storing bits; the rest read zero
    localparam logic [7:0] CORE0_STORE_MASK = 8'h79;
    localparam int CORE0_GLOBAL_RESET_BIT = 7;
    localparam int CORE0_SERIAL_RESET_BIT = 1;
    localparam int CORE0_CHIP_ENABLE_BIT = 0;

    // Core register 1 fields
    localparam int BLC_PD_FAULT_TRIG_BIT = 7;
    localparam int BLC_PD_RANGE_HI = 6;
    localparam int BLC_PD_RANGE_LO = 5;
    localparam int BLC_OPEN_LOOP_BIT = 4;
    localparam int BLC_FAULT_EN_BIT = 3;
    localparam int BLC_BIAS_EN_BIT = 2;
    localparam int BLC_BIAS_SINK_BIT = 1;
    localparam int BLC_PD_ORIENT_BIT = 0;

    // Core register 3 fields
    localparam int CNV_ENABLE_BIT = 7;
    localparam int CNV_OSC_BIT = 6;
    localparam int CNV_RESET_BIT = 4;
    localparam int CNV_SEL_HI = 2;
    localparam int CNV_SEL_LO = 0;

    // Converter input codes
    localparam logic [2:0] CNV_SEL_TEMPERATURE = 3'h0;
    localparam logic [2:0] CNV_SEL_SUPPLY = 3'h1;
    localparam logic [2:0] CNV_SEL_BIAS_MONITOR = 3'h2;
    localparam logic [2:0] CNV_SEL_PD_MONITOR = 3'h3;

    // Transmit register 10 fields
    localparam int TXP_POWER_DOWN_BIT = 7;
    localparam int TXP_DRIVER_OFF_BIT = 6;
    localparam int TXP_INVERT_BIT = 5;
    localparam int TXP_RECOVERY_DIS_BIT = 4;
    localparam int TXP_RECOVERY_BYP_BIT = 3;
    localparam int TXP_OFFSET_OFF_BIT = 2;
    localparam int TXP_EQ_OFF_BIT = 1;
    localparam int TXP_AMP_ANALOG_BIT = 0;

    // Bits per serial byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        LDCR_IDLE = 4'b0000,
        LDCR_DEV_ADDR = 4'b0001,
        LDCR_DEV_ACK = 4'b0010,
        LDCR_REG_ADDR = 4'b0011,
        LDCR_REG_ACK = 4'b0100,
        LDCR_WR_DATA = 4'b0101,
        LDCR_WR_ACK = 4'b0110,
        LDCR_RD_DATA = 4'b0111,
        LDCR_RD_ACK = 4'b1000
    } ldcr_state_type;

endpackage

/* File: ldcr_regs.sv */
// Purpose: Control register bank of a laser driver, reached by a two-wire
//          serial slave port (start, address, register, one data byte).
// Assumes: Host drives the serial clock.
// Notes: Unmapped offsets ack, drop writes, read zero.
// Notes on behaviour
// RL1: Core0 bit 7 write of 1 defaults all registers, pulses store reset.
// RL2: Writing 1 to core0 bit 1 defaults all registers; bit reads zero.
// RL3: Core0 bit 0 enables the chip; resets to 1.
// RL4: Core1 bit 7 lets the photodiode monitor pin trigger faults.
// RL5: Core1 bits 6:5 pick photodiode range: 1X 3080, 01 1540, 00 770 uA.
// RL6: Core1 bit 4 selects open-loop bias; 0 keeps closed power loop.
// RL7: Core1 bit 3 turns fault detection on.
// RL8: Core1 bit 2 enables bias current; host clears faults by writing 0.
// RL9: Core1 bit 1 makes bias output sink; 0 sources.
// RL10: Core1 bit 0 gives photodiode orientation: 1 cathode to supply.
// RL11: Core3 bit 7 enables the converter; resets to 0.
// RL12: Core3 bit 6 enables the converter oscillator; resets to 0.
// RL13: Core3 bit 4 holds the converter in reset while 1.
// RL14: Core3 bits 2:0 select converter input; codes 1XX reserved.
// RL15: Transmit10 bit 7 powers down the transmitter.
// RL16: Transmit10 bit 6 disables the output driver.
// RL17: Transmit10 bit 5 inverts output data polarity.
// RL18: Transmit10 bit 4 disables and routes around the recovery circuit.
// RL19: Transmit10 bit 3 bypasses the recovery circuit.
// RL20: Transmit10 bit 2 disables offset cancellation.
// RL21: Transmit10 bit 1 disables and bypasses the input equalizer.
// RL22: Transmit10 bit 0 picks analog amplitude control; 0 is digital.
// RL23: Slave address 0001000, direction bit, register address, one data byte.
// RL24: Reserved read-write bits store and read back, with no other effect.
`timescale 1ns/1ps

module ldcr_regs (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic nv_store_reset,
    output logic chip_enable,
    output logic pd_monitor_fault_trigger,
    output logic [1:0] pd_current_range,
    output logic open_loop_select,
    output logic fault_detect_enable,
    output logic bias_current_enable,
    output logic bias_sink_select,
    output logic pd_orientation,
    output logic converter_enable,
    output logic converter_osc_enable,
    output logic converter_reset,
    output logic [2:0] converter_input_select,
    output logic transmit_power_down,
    output logic output_driver_off,
    output logic output_invert,
    output logic recovery_disable,
    output logic recovery_bypass,
    output logic offset_cancel_off,
    output logic equalizer_off,
    output logic amplitude_source_analog
);

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl_filt;
        logic sda_filt;
        ldcr_pkg::ldcr_state_type state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] reg_addr;
        logic sda_oe;
        logic sda_out;
        logic nv_reset;
        logic [7:0] core0;
        logic [7:0] core1;
        logic [7:0] core2;
        logic [7:0] core3;
        logic [7:0] txp10;
    } ldcr_regs_type;

    ldcr_regs_type st_r;
    ldcr_regs_type st_nxt;

    // Byte returned for a register read
    function automatic logic [7:0] read_byte(input ldcr_regs_type s);
        logic [7:0] v;
        v = ldcr_pkg::RD_UNMAPPED;
        if (s.reg_addr == ldcr_pkg::OFS_CORE_RESET_ENABLE) begin
            v = s.core0 & ldcr_pkg::CORE0_STORE_MASK; // RL1 RL2
        end else if (s.reg_addr == ldcr_pkg::OFS_BIAS_LOOP_CONFIG) begin
            v = s.core1;
        end else if (s.reg_addr == ldcr_pkg::OFS_CORE_RESERVED_TWO) begin
            v = s.core2; // RL24
        end else if (s.reg_addr == ldcr_pkg::OFS_CONVERTER_CONTROL) begin
            v = s.core3;
        end else if (s.reg_addr == ldcr_pkg::OFS_TRANSMIT_PATH_CONTROL) begin
            v = s.txp10;
        end
        return v;
    endfunction

    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic byte_done;
        logic [7:0] rd;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_seen = 1'b0;
        stop_seen = 1'b0;
        byte_done = 1'b0;
        rd = 8'h00;
        st_nxt = st_r;
        st_nxt.nv_reset = 1'b0;

        // Pin synchronisers; a level counts once stages 2 and 3 agree
        st_nxt.scl_sync = {st_r.scl_sync[1:0], scl_in};
        st_nxt.sda_sync = {st_r.sda_sync[1:0], sda_in};
        if (st_r.scl_sync[1] == st_r.scl_sync[2]) begin
            st_nxt.scl_filt = st_r.scl_sync[2];
        end
        if (st_r.sda_sync[1] == st_r.sda_sync[2]) begin
            st_nxt.sda_filt = st_r.sda_sync[2];
        end

        scl_rise = st_nxt.scl_filt & ~st_r.scl_filt;
        scl_fall = ~st_nxt.scl_filt & st_r.scl_filt;
        // Start and stop: data moves while the clock stays high
        start_seen = st_r.scl_filt & st_nxt.scl_filt & st_r.sda_filt
            & ~st_nxt.sda_filt;
        stop_seen = st_r.scl_filt & st_nxt.scl_filt & ~st_r.sda_filt
            & st_nxt.sda_filt;
        byte_done = scl_fall && (st_r.bit_cnt == ldcr_pkg::BITS_PER_BYTE);

        if (start_seen) begin
            // Repeated start keeps the register address
            st_nxt.state = ldcr_pkg::LDCR_DEV_ADDR; // RL23
            st_nxt.bit_cnt = 4'h0;
            st_nxt.sda_oe = 1'b0;
        end else if (stop_seen) begin
            st_nxt.state = ldcr_pkg::LDCR_IDLE;
            st_nxt.sda_oe = 1'b0;
        end else begin
            case (st_r.state)
                ldcr_pkg::LDCR_DEV_ADDR,
                ldcr_pkg::LDCR_REG_ADDR,
                ldcr_pkg::LDCR_WR_DATA: begin
                    if (scl_rise) begin
                        st_nxt.shift = {st_r.shift[6:0], st_r.sda_filt};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        st_nxt.sda_oe = 1'b1;
                        if (st_r.state == ldcr_pkg::LDCR_DEV_ADDR) begin
                            if (st_r.shift[7:1] == ldcr_pkg::DEV_ADDR) begin
                                st_nxt.state = ldcr_pkg::LDCR_DEV_ACK; // RL23
                            end else begin
                                st_nxt.state = ldcr_pkg::LDCR_IDLE;
                                st_nxt.sda_oe = 1'b0;
                            end
                        end else if (st_r.state
                            == ldcr_pkg::LDCR_REG_ADDR) begin
                            st_nxt.reg_addr = st_r.shift; // RL23
                            st_nxt.state = ldcr_pkg::LDCR_REG_ACK;
                        end else begin
                            st_nxt.state = ldcr_pkg::LDCR_WR_ACK;
                            if (st_r.reg_addr
                                == ldcr_pkg::OFS_CORE_RESET_ENABLE) begin
                                if (st_r.shift[
                                    ldcr_pkg::CORE0_GLOBAL_RESET_BIT]) begin
                                    st_nxt.nv_reset = 1'b1; // RL1
                                end
                                if (st_r.shift[
                                    ldcr_pkg::CORE0_GLOBAL_RESET_BIT]
                                    || st_r.shift[
                                    ldcr_pkg::CORE0_SERIAL_RESET_BIT]) begin
                                    st_nxt.core0 = // RL1 RL2
                                        ldcr_pkg::RST_CORE_RESET_ENABLE;
                                    st_nxt.core1 =
                                        ldcr_pkg::RST_BIAS_LOOP_CONFIG;
                                    st_nxt.core2 =
                                        ldcr_pkg::RST_CORE_RESERVED_TWO;
                                    st_nxt.core3 =
                                        ldcr_pkg::RST_CONVERTER_CONTROL;
                                    st_nxt.txp10 =
                                        ldcr_pkg::RST_TRANSMIT_PATH_CONTROL;
                                end else begin
                                    // Self-clearing bits are never stored
                                    st_nxt.core0 = st_r.shift // RL3 RL24
                                        & ldcr_pkg::CORE0_STORE_MASK;
                                end
                            end else if (st_r.reg_addr
                                == ldcr_pkg::OFS_BIAS_LOOP_CONFIG) begin
                                st_nxt.core1 = st_r.shift; // RL4 RL8
                            end else if (st_r.reg_addr
                                == ldcr_pkg::OFS_CORE_RESERVED_TWO) begin
                                st_nxt.core2 = st_r.shift; // RL24
                            end else if (st_r.reg_addr
                                == ldcr_pkg::OFS_CONVERTER_CONTROL) begin
                                st_nxt.core3 = st_r.shift; // RL11 RL24
                            end else if (st_r.reg_addr
                                == ldcr_pkg::OFS_TRANSMIT_PATH_CONTROL) begin
                                st_nxt.txp10 = st_r.shift; // RL15
                            end
                        end
                    end
                end
                ldcr_pkg::LDCR_DEV_ACK: begin
                    if (scl_fall) begin
                        st_nxt.bit_cnt = 4'h0;
                        if (st_r.shift[0]) begin
                            // Read: present the first data bit at once
                            rd = read_byte(st_r);
                            st_nxt.shift = rd;
                            st_nxt.sda_oe = ~rd[7];
                            st_nxt.state = ldcr_pkg::LDCR_RD_DATA;
                        end else begin
                            st_nxt.sda_oe = 1'b0;
                            st_nxt.state = ldcr_pkg::LDCR_REG_ADDR;
                        end
                    end
                end
                ldcr_pkg::LDCR_REG_ACK: begin
                    if (scl_fall) begin
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.bit_cnt = 4'h0;
                        st_nxt.state = ldcr_pkg::LDCR_WR_DATA;
                    end
                end
                ldcr_pkg::LDCR_WR_ACK: begin
                    // One byte per transfer; later bytes go unacknowledged
                    if (scl_fall) begin
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.state = ldcr_pkg::LDCR_IDLE; // RL23
                    end
                end
                ldcr_pkg::LDCR_RD_DATA: begin
                    if (scl_rise) begin
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.state = ldcr_pkg::LDCR_RD_ACK;
                    end else if (scl_fall) begin
                        st_nxt.shift = {st_r.shift[6:0], 1'b0};
                        st_nxt.sda_oe = ~st_r.shift[6];
                    end
                end
                ldcr_pkg::LDCR_RD_ACK: begin
                    if (scl_fall) begin
                        st_nxt.state = ldcr_pkg::LDCR_IDLE;
                    end
                end
                default: begin
                    st_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r.scl_sync <= 3'h7;
            st_r.sda_sync <= 3'h7;
            st_r.scl_filt <= 1'b1;
            st_r.sda_filt <= 1'b1;
            st_r.state <= ldcr_pkg::LDCR_IDLE;
            st_r.bit_cnt <= 4'h0;
            st_r.shift <= 8'h00;
            st_r.reg_addr <= 8'h00;
            st_r.sda_oe <= 1'b0;
            st_r.sda_out <= 1'b0;
            st_r.nv_reset <= 1'b0;
            st_r.core0 <= ldcr_pkg::RST_CORE_RESET_ENABLE; // RL3
            st_r.core1 <= ldcr_pkg::RST_BIAS_LOOP_CONFIG;
            st_r.core2 <= ldcr_pkg::RST_CORE_RESERVED_TWO;
            st_r.core3 <= ldcr_pkg::RST_CONVERTER_CONTROL; // RL11 RL12
            st_r.txp10 <= ldcr_pkg::RST_TRANSMIT_PATH_CONTROL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Open-drain data pin: only ever pulled low
    assign sda_out = st_r.sda_out;
    assign sda_oe = st_r.sda_oe;
    assign nv_store_reset = st_r.nv_reset; // RL1

    assign chip_enable = st_r.core0[ldcr_pkg::CORE0_CHIP_ENABLE_BIT]; // RL3
    assign pd_monitor_fault_trigger =
        st_r.core1[ldcr_pkg::BLC_PD_FAULT_TRIG_BIT]; // RL4
    assign pd_current_range =
        st_r.core1[ldcr_pkg::BLC_PD_RANGE_HI:ldcr_pkg::BLC_PD_RANGE_LO]; // RL5
    assign open_loop_select = st_r.core1[ldcr_pkg::BLC_OPEN_LOOP_BIT]; // RL6
    assign fault_detect_enable = st_r.core1[ldcr_pkg::BLC_FAULT_EN_BIT]; // RL7
    assign bias_current_enable = st_r.core1[ldcr_pkg::BLC_BIAS_EN_BIT]; // RL8
    assign bias_sink_select = st_r.core1[ldcr_pkg::BLC_BIAS_SINK_BIT]; // RL9
    assign pd_orientation = st_r.core1[ldcr_pkg::BLC_PD_ORIENT_BIT]; // RL10
    assign converter_enable = st_r.core3[ldcr_pkg::CNV_ENABLE_BIT]; // RL11
    assign converter_osc_enable = st_r.core3[ldcr_pkg::CNV_OSC_BIT]; // RL12
    assign converter_reset = st_r.core3[ldcr_pkg::CNV_RESET_BIT]; // RL13
    assign converter_input_select =
        st_r.core3[ldcr_pkg::CNV_SEL_HI:ldcr_pkg::CNV_SEL_LO]; // RL14
    assign transmit_power_down =
        st_r.txp10[ldcr_pkg::TXP_POWER_DOWN_BIT]; // RL15
    assign output_driver_off =
        st_r.txp10[ldcr_pkg::TXP_DRIVER_OFF_BIT]; // RL16
    assign output_invert = st_r.txp10[ldcr_pkg::TXP_INVERT_BIT]; // RL17
    assign recovery_disable =
        st_r.txp10[ldcr_pkg::TXP_RECOVERY_DIS_BIT]; // RL18
    assign recovery_bypass =
        st_r.txp10[ldcr_pkg::TXP_RECOVERY_BYP_BIT]; // RL19
    assign offset_cancel_off =
        st_r.txp10[ldcr_pkg::TXP_OFFSET_OFF_BIT]; // RL20
    assign equalizer_off = st_r.txp10[ldcr_pkg::TXP_EQ_OFF_BIT]; // RL21
    assign amplitude_source_analog =
        st_r.txp10[ldcr_pkg::TXP_AMP_ANALOG_BIT]; // RL22

endmodule

/* File: ldcr_regs_props.sv */
// Purpose: Port checks of the register bank.
// Assumes: Serial clock phases last well over four system clocks.
// Notes: Bound to the register bank.
`timescale 1ns/1ps

module ldcr_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic nv_store_reset,
    input wire logic chip_enable,
    input wire logic [1:0] pd_current_range,
    input wire logic bias_current_enable,
    input wire logic converter_enable,
    input wire logic converter_osc_enable,
    input wire logic [2:0] converter_input_select,
    input wire logic transmit_power_down
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sda_out_zero_a: assert property (sda_out == 1'b0)
        else $error("data drive value is not low");
    enable_after_reset_a: assert property ($fell(sys_rst) |->
        chip_enable)
        else $error("chip enable not set out of reset");
    conv_after_reset_a: assert property ($fell(sys_rst) |->
        !converter_enable && !converter_osc_enable)
        else $error("converter bits not clear out of reset");
    idle_after_reset_a: assert property ($fell(sys_rst) |->
        (!sda_oe) [*4])
        else $error("data line pulled right after reset");
    nv_pulse_one_a: assert property (nv_store_reset |=> !nv_store_reset)
        else $error("store reset pulse longer than one cycle");
    nv_defaults_a: assert property (nv_store_reset |-> ##[0:2]
        (chip_enable && !bias_current_enable && !converter_enable &&
        !transmit_power_down && pd_current_range == 2'h0))
        else $error("global reset left registers off default");
    outputs_on_ack_a: assert property ($changed({chip_enable,
        pd_current_range, bias_current_enable, converter_enable,
        converter_input_select, transmit_power_down}) |-> ##[0:1] sda_oe)
        else $error("control output changed outside a write ack");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved while serial clock high");

    cover property (nv_store_reset);
    cover property ($rose(sda_oe));
    cover property ($fell(chip_enable));
endmodule

bind ldcr_regs ldcr_props u_ldcr_props (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .nv_store_reset(nv_store_reset),
    .chip_enable(chip_enable), .pd_current_range(pd_current_range),
    .bias_current_enable(bias_current_enable),
    .converter_enable(converter_enable),
    .converter_osc_enable(converter_osc_enable),
    .converter_input_select(converter_input_select),
    .transmit_power_down(transmit_power_down)
);

/* File: ldcr_host.sv */
// Purpose: Host controller model driving the two-wire serial bus.
// Assumes: Data line resolved outside, pulled up.
// Notes: Data moves two clocks after a clock fall.
`timescale 1ns/1ps

module ldcr_host (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    localparam int HALF = 8;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_half();
        repeat (HALF) @(negedge clock);
    endtask
    task automatic low_phase(input logic v);
        repeat (2) @(negedge clock);
        sda_drv = v;
        wait_half();
    endtask
    task automatic pulse(output logic s);
        scl = 1'b1;
        wait_half();
        s = sda;
        scl = 1'b0;
    endtask
    task automatic start_cond();
        low_phase(1'b1);
        scl = 1'b1;
        wait_half();
        sda_drv = 1'b0;
        wait_half();
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        low_phase(1'b0);
        scl = 1'b1;
        wait_half();
        sda_drv = 1'b1;
        wait_half();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            low_phase(b[i]);
            pulse(s);
        end
        low_phase(1'b1);
        pulse(s);
        ack = !s;
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
        input logic [7:0] dat, input logic extra, output logic [3:0] acks);
        acks = 4'h0;
        start_cond();
        send_byte({dev, 1'b0}, acks[3]);
        send_byte(ofs, acks[2]);
        send_byte(dat, acks[1]);
        if (extra) begin
            send_byte(~dat, acks[0]);
        end
        stop_cond();
    endtask
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d,
        output logic [2:0] acks);
        logic s;
        start_cond();
        send_byte({ldcr_pkg::DEV_ADDR, 1'b0}, acks[2]);
        send_byte(ofs, acks[1]);
        start_cond();
        send_byte({ldcr_pkg::DEV_ADDR, 1'b1}, acks[0]);
        for (int i = 7; i >= 0; i--) begin
            low_phase(1'b1);
            pulse(d[i]);
        end
        low_phase(1'b1);
        pulse(s);
        stop_cond();
    endtask
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the register bank.
// Assumes: Host model paces the serial clock.
// Notes: A bench model holds expected contents.
`timescale 1ns/1ps

module testbench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, sda_drv, sda_out, sda_oe, nv_store_reset, chip_enable;
    logic pd_monitor_fault_trigger, open_loop_select, fault_detect_enable;
    logic bias_current_enable, bias_sink_select, pd_orientation;
    logic converter_enable, converter_osc_enable, converter_reset;
    logic transmit_power_down, output_driver_off, output_invert;
    logic recovery_disable, recovery_bypass, offset_cancel_off;
    logic equalizer_off, amplitude_source_analog;
    logic [1:0] pd_current_range;
    logic [2:0] converter_input_select;
    wire sda = sda_drv & ~sda_oe;
    int n_fail = 0;
    int n_compared = 0;
    int n_nv = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h7;
    logic [7:0] m [0:15];
    logic [7:0] offs [0:4] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A};

    always #10 clock = ~clock;

    ldcr_regs u_ldcr_regs (.clock(clock), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .nv_store_reset(nv_store_reset), .chip_enable(chip_enable),
        .pd_monitor_fault_trigger(pd_monitor_fault_trigger),
        .pd_current_range(pd_current_range),
        .open_loop_select(open_loop_select),
        .fault_detect_enable(fault_detect_enable),
        .bias_current_enable(bias_current_enable),
        .bias_sink_select(bias_sink_select), .pd_orientation(pd_orientation),
        .converter_enable(converter_enable),
        .converter_osc_enable(converter_osc_enable),
        .converter_reset(converter_reset),
        .converter_input_select(converter_input_select),
        .transmit_power_down(transmit_power_down),
        .output_driver_off(output_driver_off), .output_invert(output_invert),
        .recovery_disable(recovery_disable),
        .recovery_bypass(recovery_bypass),
        .offset_cancel_off(offset_cancel_off), .equalizer_off(equalizer_off),
        .amplitude_source_analog(amplitude_source_analog));
    ldcr_host u_ldcr_host (.clock(clock), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask
    task automatic mdefaults();
        for (int i = 0; i < 16; i++) begin
            m[i] = 8'h00;
        end
        m[0] = ldcr_pkg::RST_CORE_RESET_ENABLE;
    endtask
    task automatic mwrite(input logic [7:0] ofs, input logic [7:0] d);
        if (ofs == 8'h00 && (d[7] || d[1])) begin
            mdefaults();
        end else if (ofs == 8'h00) begin
            m[0] = d & ldcr_pkg::CORE0_STORE_MASK;
        end else if (ofs < 8'h04 || ofs == 8'h0A) begin
            m[ofs[3:0]] = d;
        end
    endtask
    task automatic chk_outs();
        chk({7'h00, chip_enable}, {7'h00, m[0][0]}, "chip");
        chk({pd_monitor_fault_trigger, pd_current_range, open_loop_select,
            fault_detect_enable, bias_current_enable, bias_sink_select,
            pd_orientation}, m[1], "bias");
        chk({2'h0, converter_enable, converter_osc_enable, converter_reset,
            converter_input_select}, {2'h0, m[3][7:6], m[3][4], m[3][2:0]},
            "conv");
        chk({transmit_power_down, output_driver_off, output_invert,
            recovery_disable, recovery_bypass, offset_cancel_off,
            equalizer_off, amplitude_source_analog}, m[10],
            "txp");
    endtask
    task automatic wr_chk(input logic [7:0] ofs, input logic [7:0] d);
        logic [3:0] a;
        u_ldcr_host.write_reg(ldcr_pkg::DEV_ADDR, ofs, d, 1'b0, a);
        mwrite(ofs, d);
        chk({4'h0, a}, 8'h0E, "write acks");
        chk_outs();
    endtask
    task automatic rd_chk(input logic [7:0] ofs);
        logic [7:0] d;
        logic [2:0] a;
        u_ldcr_host.read_reg(ofs, d, a);
        chk({5'h00, a}, 8'h07, "read acks");
        chk(d, (ofs < 8'h10) ? m[ofs[3:0]] : 8'h00, "read data");
    endtask

    always @(negedge clock) begin
        cycles++;
        if (nv_store_reset === 1'b1) begin
            n_nv++;
        end
        if (cycles == 80000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        logic [3:0] a;
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        mdefaults();
        chk_outs();
        for (int i = 0; i < 5; i++) begin
            rd_chk(offs[i]);
        end
        rd_chk(8'h05);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            wr_chk(offs[seed % 5], seed[15:8] & 8'h7D);
            rd_chk(offs[seed % 5]);
        end
        for (int c = 0; c < 8; c++) begin
            seed = xs(seed);
            wr_chk(8'h03, {seed[7:3], c[2:0]});
            rd_chk(8'h03);
        end
        wr_chk(8'h01, 8'h0C);
        wr_chk(8'h01, 8'h08);
        wr_chk(8'h00, 8'h00);
        rd_chk(8'h00);
        wr_chk(8'h05, 8'hA5);
        rd_chk(8'h05);
        wr_chk(8'h03, 8'hFF);
        wr_chk(8'h0A, 8'h5A);
        wr_chk(8'h00, 8'h02);
        rd_chk(8'h00);
        chk(n_nv[7:0], 8'h00, "no store reset");
        wr_chk(8'h0A, 8'hC3);
        wr_chk(8'h00, 8'h80);
        rd_chk(8'h00);
        chk(n_nv[7:0], 8'h01, "store reset count");
        u_ldcr_host.write_reg(7'h09, 8'h01, 8'hFF, 1'b0, a);
        chk({4'h0, a}, 8'h00, "foreign address");
        chk_outs();
        u_ldcr_host.write_reg(ldcr_pkg::DEV_ADDR, 8'h01, 8'h33, 1'b1, a);
        mwrite(8'h01, 8'h33);
        chk({4'h0, a}, 8'h0E, "extra byte");
        chk_outs();
        tally_and_finish();
    end
endmodule
